// *** rtl/edi_pkg.sv ***
package edi_pkg;
    // identification word geometry
    localparam int ID_W = 32;
    localparam int ID_MSB = 31;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] ID_BITS = 6'h20;

    // synchroniser depth, link inputs
    localparam int SYNC_STAGES = 2;
    localparam int LNK_IN_W = 5;

    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
    localparam logic SEL_PREV_RST = 1'b1;
    localparam logic READY_O_RST = 1'b1;
    localparam logic READY_OE_RST = 1'b0;
    localparam logic MOTOR_RUN_RST = 1'b0;
    localparam logic RD_ARM_RST = 1'b0;

    // motor state of the drive
    typedef enum logic [0:0] {
        EDI_MOTOR_OFF = 1'b0,
        EDI_MOTOR_ON = 1'b1
    } edi_motor_t;
endpackage

// *** rtl/edi_sync2.sv ***
module edi_sync2 import edi_pkg::*; #(
    parameter int W = 1
) (
    // destination clock
    input wire logic dst_clk,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    ////////////////////////////////////////////////////////////////
    // first stage feeds only the second stage
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d_in;
        q_nxt = meta_r;
    end

    // no reset: the stages flush within two edges anyway
    always_ff @(posedge dst_clk) begin
        meta_r <= meta_nxt;
        q_r <= q_nxt;
    end

    assign q_out = q_r;
endmodule

// *** rtl/edi_id_readout.sv ***
module edi_id_readout import edi_pkg::*; #(
    // arbitrary value, identifies this drive type
    parameter logic [ID_W-1:0] ID_WORD = 32'h3c96_0a5f
) (
    // system clock domain
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic disk_ready,
    output logic motor_running,
    // link clock domain
    input wire logic link_clk,
    input wire logic drive_select_n,
    input wire logic motor_on_data_n,
    input wire logic host_reset_n,
    // ready line, two-way pin
    input wire logic ready_line_i,
    output logic ready_line_o,
    output logic ready_line_oe
);
    ////////////////////////////////////////////////////////////////
    // crossings into the link domain
    logic [LNK_IN_W-1:0] lnk_in_s;
    logic sel_n_s;
    logic mtr_n_s;
    logic hrst_n_s;
    logic lnk_rst_s;
    logic disk_ready_s;

    // disk_ready and sys_rst are levels, two flops suffice
    edi_sync2 #(.W(LNK_IN_W)) u_to_link (
        .dst_clk(link_clk),
        .d_in({drive_select_n, motor_on_data_n, host_reset_n, sys_rst, disk_ready}),
        .q_out(lnk_in_s)
    );

    assign sel_n_s = lnk_in_s[4];
    assign mtr_n_s = lnk_in_s[3];
    assign hrst_n_s = lnk_in_s[2];
    assign lnk_rst_s = lnk_in_s[1];
    assign disk_ready_s = lnk_in_s[0];

    ////////////////////////////////////////////////////////////////
    // link side: motor flip-flop, shift register, ready pin
    edi_motor_t motor_r;
    edi_motor_t motor_nxt;
    logic sel_prev_r;
    logic sel_prev_nxt;
    logic [ID_W-1:0] shift_r;
    logic [ID_W-1:0] shift_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic ready_o_r;
    logic ready_o_nxt;
    logic ready_oe_r;
    logic ready_oe_nxt;
    logic rd_arm_r;
    logic rd_arm_nxt;
    logic sel_fall;
    logic sel_rise;
    logic line_bit;

    always_comb begin
        sel_fall = sel_prev_r & ~sel_n_s;
        sel_rise = ~sel_prev_r & sel_n_s;
        sel_prev_nxt = sel_n_s;
        motor_nxt = motor_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        rd_arm_nxt = rd_arm_r;
        line_bit = 1'b0;

        // select going active latches the motor data line
        if (sel_fall) begin
            motor_nxt = mtr_n_s ? EDI_MOTOR_OFF : EDI_MOTOR_ON;
        end
        // either reset wins over a select edge in the same cycle
        if (lnk_rst_s || !hrst_n_s) begin
            motor_nxt = EDI_MOTOR_OFF;
        end

        // only a pulse that began with the motor off and left it off is a read pulse;
        // the deselect closing the on-off sequence must not eat bit 31
        if (sel_fall) begin
            rd_arm_nxt = (motor_r == EDI_MOTOR_OFF) && (motor_nxt == EDI_MOTOR_OFF);
        end else if (sel_rise) begin
            rd_arm_nxt = 1'b0;
        end

        // host owns the on-off sequence that starts a readout
        if (motor_r == EDI_MOTOR_ON && motor_nxt == EDI_MOTOR_OFF) begin
            shift_nxt = ID_WORD;
            cnt_nxt = CNT_RST;
        end else if (motor_r == EDI_MOTOR_OFF && sel_rise && rd_arm_r && cnt_r != ID_BITS) begin
            // advance only on deselect, so the bit is stable while sampled
            shift_nxt = {shift_r[ID_MSB-1:0], 1'b0};
            cnt_nxt = cnt_r + 6'h01;
        end

        case (motor_r)
            EDI_MOTOR_ON: line_bit = disk_ready_s;
            EDI_MOTOR_OFF: line_bit = shift_r[ID_MSB];
            default: line_bit = 1'b0;
        endcase

        // shared line: drive it only while this drive is selected
        ready_oe_nxt = ~sel_n_s;
        // value frozen while driven, so a motor change mid-pulse cannot move it
        ready_o_nxt = ready_oe_r ? ready_o_r : ~line_bit;
    end

    always_ff @(posedge link_clk) begin
        if (lnk_rst_s) begin
            motor_r <= EDI_MOTOR_OFF;
            sel_prev_r <= SEL_PREV_RST;
            shift_r <= ID_WORD;
            cnt_r <= CNT_RST;
            rd_arm_r <= RD_ARM_RST;
            ready_o_r <= READY_O_RST;
            ready_oe_r <= READY_OE_RST;
        end else begin
            motor_r <= motor_nxt;
            sel_prev_r <= sel_prev_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            rd_arm_r <= rd_arm_nxt;
            ready_o_r <= ready_o_nxt;
            ready_oe_r <= ready_oe_nxt;
        end
    end

    assign ready_line_o = ready_o_r;
    assign ready_line_oe = ready_oe_r;

    ////////////////////////////////////////////////////////////////
    // system side: motor state for the spindle logic
    logic motor_s;
    logic motor_run_r;
    logic motor_run_nxt;
    logic unused_line;

    // ready line is only ever driven here; its read-back is not needed
    assign unused_line = ready_line_i;

    edi_sync2 #(.W(1)) u_to_sys (
        .dst_clk(clk),
        .d_in(motor_r == EDI_MOTOR_ON),
        .q_out(motor_s)
    );

    always_comb begin
        motor_run_nxt = motor_s & ~unused_line | motor_s & unused_line;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            motor_run_r <= MOTOR_RUN_RST;
        end else begin
            motor_run_r <= motor_run_nxt;
        end
    end

    assign motor_running = motor_run_r;
endmodule

// *** tb/edi_chk.sv ***
module edi_chk (
    // watched ports
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic motor_running,
    input wire logic link_clk,
    input wire logic drive_select_n,
    input wire logic host_reset_n,
    input wire logic ready_line_o,
    input wire logic ready_line_oe
);
    // idle cycles count, motor output must settle long before it saturates
    logic [3:0] idle_cnt_r;
    always_ff @(posedge clk) begin
        if (sys_rst || !drive_select_n || !host_reset_n) begin
            idle_cnt_r <= 4'h0;
        end else if (idle_cnt_r != 4'hf) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
        end
    end
    property p_ans; @(posedge link_clk) disable iff (sys_rst)
        $fell(drive_select_n) |-> ##[2:10] ready_line_oe; endproperty
    a_ans: assert property (p_ans) else $error("oe late");
    property p_cause; @(posedge link_clk) disable iff (sys_rst)
        $rose(ready_line_oe) |-> !drive_select_n && !$past(drive_select_n, 3); endproperty
    a_cause: assert property (p_cause) else $error("oe early");
    property p_rel; @(posedge link_clk) disable iff (sys_rst)
        $rose(drive_select_n) |-> ##[2:10] !ready_line_oe; endproperty
    a_rel: assert property (p_rel) else $error("oe stuck");
    property p_drop; @(posedge link_clk) disable iff (sys_rst)
        $fell(ready_line_oe) |-> drive_select_n && $past(drive_select_n, 3); endproperty
    a_drop: assert property (p_drop) else $error("oe dropped");
    property p_hold; @(posedge link_clk) disable iff (sys_rst)
        ready_line_oe && $past(ready_line_oe) |-> $stable(ready_line_o); endproperty
    a_hold: assert property (p_hold) else $error("bit moved");
    property p_rst; @(posedge clk) sys_rst |=> !motor_running; endproperty
    a_rst: assert property (p_rst) else $error("motor in reset");
    property p_still; @(posedge clk) disable iff (sys_rst)
        idle_cnt_r == 4'hf |-> $stable(motor_running); endproperty
    a_still: assert property (p_still) else $error("motor moved");
    property p_hrst; @(posedge clk) disable iff (sys_rst)
        !host_reset_n [*8] |=> ##3 !motor_running; endproperty
    a_hrst: assert property (p_hrst) else $error("motor kept");
endmodule
////////////////
bind edi_id_readout edi_chk u_edi_chk (.clk, .sys_rst, .motor_running, .link_clk, .drive_select_n,
    .host_reset_n, .ready_line_o, .ready_line_oe);

// *** tb/edi_host_model.sv ***
module edi_host_model (
    // clock
    input wire logic clk,
    // drive pins
    input wire logic ready_line,
    output logic drive_select_n,
    output logic motor_on_data_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        drive_select_n = 1'b1;
        motor_on_data_n = 1'b1;
    end
    ////////////////
    // 12 clk per half, beyond four link periods
    task automatic strobe(input logic m, output logic b);
        motor_on_data_n = m;
        drive_select_n = 1'b0;
        repeat (12) @(negedge clk);
        b = ~ready_line;
        drive_select_n = 1'b1;
        repeat (12) @(negedge clk);
    endtask
    task automatic read_word(input int n, output logic [31:0] w);
        logic b;
        w = 32'h0;
        repeat (n) begin
            strobe(1'b1, b);
            w = {w[30:0], b};
        end
    endtask
endmodule

// *** tb/edi_id_readout_tb_top.sv ***
module edi_id_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // arbitrary word
    localparam logic [31:0] TB_ID = 32'hc3a5_0f96;
    logic clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, disk_ready = 1'b0, host_reset_n = 1'b1;
    logic motor_running, ready_line_o, ready_line_oe, drive_select_n, motor_on_data_n, rdy, b;
    logic [31:0] w;
    int n_errors = 0, checks = 0, n;
    always #10 clk = ~clk;
    always #24 link_clk = ~link_clk;
    // released pin sits at the pull-up level
    assign rdy = ready_line_oe ? ready_line_o : 1'b1;
    edi_id_readout #(.ID_WORD(TB_ID)) u_edi_id_readout (.clk, .sys_rst, .disk_ready, .motor_running, .link_clk,
        .drive_select_n, .motor_on_data_n, .host_reset_n, .ready_line_i(rdy), .ready_line_o, .ready_line_oe);
    edi_host_model u_edi_host_model (.clk, .ready_line(rdy), .drive_select_n, .motor_on_data_n);
    ////////////////
    function automatic logic [31:0] head(int k);
        return TB_ID >> (32 - k);
    endfunction
    task automatic chk(string s, logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // run needs 950 to 1670 cycles, depending on the random head length
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hbf410a11));
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (12) @(negedge clk);
        n = 1 + int'($urandom % 31);
        u_edi_host_model.read_word(n, w);
        chk("head", w, head(n));
        disk_ready = 1'($urandom);
        u_edi_host_model.strobe(1'b0, b);
        u_edi_host_model.strobe(1'b0, b);
        chk("ready", 32'(b), 32'(disk_ready));
        chk("motor", 32'(motor_running), 32'h1);
        host_reset_n = 1'b0;
        repeat (16) @(negedge clk);
        host_reset_n = 1'b1;
        chk("motor clr", 32'(motor_running), 32'h0);
        u_edi_host_model.strobe(1'b0, b);
        u_edi_host_model.strobe(1'b1, b);
        u_edi_host_model.read_word(32, w);
        chk("word", w, TB_ID);
        u_edi_host_model.read_word(1, w);
        chk("past end", w, 32'h0);
        tally_and_finish();
    end
endmodule
